/* rtl/drc_cfg.svh */
// Function
// - MPC cal then CAS-2 drives 16-bit burst
// - Pattern bytes default 5a/3c, masks 55
// - Mask bit one inverts that lane
// - Lower mask lanes 0-7, upper 8-15
// - Mask/inversion lanes never inverted
// - Pattern bytes sent LSB first
// - Inversion lanes driven in cal only with DBI-read, always in FIFO reads
// - Cal pairs decoded back to back, but one due mid-burst is dropped with launch_overrun
// - Calibration allowed in any bank state
// - MPC op bit6 low is NOP
// - FIFO write WL from CAS-2 2nd edge
// - FIFO read RL from CAS-2 2nd edge
// - Five-entry FIFO of 16-beat bursts
// - FIFO reads do not destroy data
// - Reads step 0..4 then wrap
// - Write pointer reset at reset, power-down
// - FIFO cmds advance own pointer, RD both
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH
`define DRC_MR_PAT1 6'h20
`define DRC_MR_PAT2 6'h28
`define DRC_MR_MSK_LO 6'h0f
`define DRC_MR_MSK_HI 6'h14
`define DRC_MR_RDCFG 6'h03
`define DRC_RDCFG_DBI_BIT 6
`define DRC_PAT1_RST 8'h5a
`define DRC_PAT2_RST 8'h3c
`define DRC_MSK_RST 8'h55
`define DRC_MPC_EN_BIT 6
`define DRC_MPC_RDCAL 6'h03
`define DRC_MPC_WRFIFO 6'h07
`define DRC_MPC_RDFIFO 6'h01
`define DRC_FIFO_LAST 3'h4
`define DRC_BEAT_LAST 4'hf
`endif

/* rtl/drc_pkg.sv */
package drc_pkg;
   typedef enum logic [3:0] {
      DRC_NOP, DRC_MPC, DRC_CAS2, DRC_RD, DRC_RDA, DRC_WR, DRC_MWR,
      DRC_MRW, DRC_MRR, DRC_PDE, DRC_SRPDE
   } drc_cmd_t;
   typedef enum logic [1:0] {DRC_K_CAL, DRC_K_FWR, DRC_K_FRD} drc_kind_t;
   typedef enum logic {DRC_IDLE, DRC_BURST} drc_state_t;
   typedef struct packed {
      logic v;
      drc_kind_t k;
      logic [2:0] idx;
   } drc_entry_t;
   typedef struct packed {
      drc_kind_t k;
      logic [2:0] idx;
      logic [7:0] pat1;
      logic [7:0] pat2;
      logic [15:0] mask;
      logic dbi;
   } drc_launch_t;
endpackage

/* rtl/drc_train.sv */
`timescale 1ns/1ps
`include "drc_cfg.svh"
module drc_train #(
   parameter int LAT_W = 5
) (
   // Command clock domain
   input wire logic clk,
   input wire logic reset_n,
   // Command bus
   input wire drc_pkg::drc_cmd_t cmd_code,
   input wire logic [5:0] cmd_ma,
   input wire logic [7:0] cmd_op,
   // Current latencies in command clocks
   input wire logic [LAT_W-1:0] read_latency,
   input wire logic [LAT_W-1:0] write_latency,
   // Strobe domain
   input wire logic link_clk,
   input wire logic [15:0] dq_in,
   input wire logic [1:0] mask_inversion_lane_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe_n,
   output logic [1:0] mask_inversion_lane_out,
   output logic [1:0] mask_inversion_lane_oe_n,
   // Status
   output logic [2:0] wr_ptr,
   output logic [2:0] rd_ptr,
   output logic read_bus_inversion_enable,
   output logic launch_overrun
);
   import drc_pkg::*;
   localparam int DEPTH = 2 ** LAT_W;

   typedef struct packed {
      logic pend_v;
      drc_kind_t pend_k;
      logic [7:0] pat1;
      logic [7:0] pat2;
      logic [7:0] msk_lo;
      logic [7:0] msk_hi;
      logic dbi;
      logic [2:0] wptr;
      logic [2:0] rptr;
      drc_entry_t [DEPTH-1:0] pipe;
      logic req;
      drc_launch_t word;
      logic ack_s1;
      logic ack_s2;
      logic overrun;
   } drc_cstate_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic ack;
      drc_state_t st;
      drc_launch_t w;
      logic [3:0] beat;
      logic [4:0][15:0][17:0] mem;
      logic [15:0] dq;
      logic [15:0] dq_oe_n;
      logic [1:0] mask_inversion_lane;
      logic [1:0] dmi_oe_n;
   } drc_lstate_t;

   drc_cstate_t s_q, s_d;
   drc_lstate_t l_q, l_d;

   function automatic logic [2:0] drc_next(input logic [2:0] p);
      drc_next = (p == `DRC_FIFO_LAST) ? 3'h0 : p + 3'h1;
   endfunction

   // Command clock side
   always_comb begin
      drc_entry_t e;
      logic [LAT_W-1:0] lat;
      e = '0;
      lat = read_latency;
      s_d = s_q;
      s_d.ack_s1 = l_q.ack;
      s_d.ack_s2 = s_q.ack_s1;
      s_d.overrun = 1'b0;
      s_d.pend_v = 1'b0;
      for (int i = 0; i < DEPTH - 1; i++) begin
         s_d.pipe[i] = s_q.pipe[i+1];
      end
      s_d.pipe[DEPTH-1] = '0;
      // No bank or refresh state gates calibration
      case (cmd_code)
         DRC_MPC: begin
            if (cmd_op[`DRC_MPC_EN_BIT]) begin
               case (cmd_op[5:0])
                  `DRC_MPC_RDCAL: begin
                     s_d.pend_v = 1'b1;
                     s_d.pend_k = DRC_K_CAL;
                  end
                  `DRC_MPC_WRFIFO: begin
                     s_d.pend_v = 1'b1;
                     s_d.pend_k = DRC_K_FWR;
                  end
                  `DRC_MPC_RDFIFO: begin
                     s_d.pend_v = 1'b1;
                     s_d.pend_k = DRC_K_FRD;
                  end
                  default: s_d.pend_v = 1'b0;
               endcase
            end
         end
         DRC_CAS2: begin
            // Operands ignored, controller holds them low
            if (s_q.pend_v) begin
               e.v = 1'b1;
               e.k = s_q.pend_k;
               case (s_q.pend_k)
                  DRC_K_FWR: begin
                     lat = write_latency;
                     e.idx = s_q.wptr;
                     s_d.wptr = drc_next(s_q.wptr);
                  end
                  DRC_K_FRD: begin
                     e.idx = s_q.rptr;
                     s_d.rptr = drc_next(s_q.rptr);
                  end
                  default: e.idx = 3'h0;
               endcase
               s_d.pipe[lat] = e;
            end
         end
         DRC_RD, DRC_RDA: begin
            s_d.wptr = drc_next(s_q.wptr);
            s_d.rptr = drc_next(s_q.rptr);
         end
         DRC_PDE, DRC_SRPDE: begin
            s_d.wptr = 3'h0;
            s_d.rptr = 3'h0;
         end
         DRC_MRW: begin
            case (cmd_ma)
               `DRC_MR_PAT1: s_d.pat1 = cmd_op;
               `DRC_MR_PAT2: s_d.pat2 = cmd_op;
               `DRC_MR_MSK_LO: s_d.msk_lo = cmd_op;
               `DRC_MR_MSK_HI: s_d.msk_hi = cmd_op;
               `DRC_MR_RDCFG: s_d.dbi = cmd_op[`DRC_RDCFG_DBI_BIT];
               default: s_d.dbi = s_q.dbi;
            endcase
         end
         default: s_d.pend_v = 1'b0;
      endcase
      // Hand a due burst to the strobe domain, one in flight
      if (s_q.pipe[0].v) begin
         if (s_q.req == s_q.ack_s2) begin
            s_d.req = ~s_q.req;
            s_d.word.k = s_q.pipe[0].k;
            s_d.word.idx = s_q.pipe[0].idx;
            s_d.word.pat1 = s_q.pat1;
            s_d.word.pat2 = s_q.pat2;
            s_d.word.mask = {s_q.msk_hi, s_q.msk_lo};
            s_d.word.dbi = s_q.dbi;
         end else begin
            s_d.overrun = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.pat1 <= `DRC_PAT1_RST;
         s_q.pat2 <= `DRC_PAT2_RST;
         s_q.msk_lo <= `DRC_MSK_RST;
         s_q.msk_hi <= `DRC_MSK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Strobe side
   always_comb begin
      logic [7:0] byt;
      logic bitv;
      byt = l_q.beat[3] ? l_q.w.pat2 : l_q.w.pat1;
      bitv = byt[l_q.beat[2:0]];
      l_d = l_q;
      l_d.req_s1 = s_q.req;
      l_d.req_s2 = l_q.req_s1;
      l_d.req_s3 = l_q.req_s2;
      l_d.dq_oe_n = '1;
      l_d.dmi_oe_n = '1;
      case (l_q.st)
         DRC_IDLE: begin
            if (l_q.req_s2 != l_q.req_s3) begin
               l_d.w = s_q.word;
               l_d.st = DRC_BURST;
               l_d.beat = 4'h0;
            end
         end
         DRC_BURST: begin
            case (l_q.w.k)
               DRC_K_CAL: begin
                  l_d.dq = {16{bitv}} ^ l_q.w.mask;
                  l_d.dq_oe_n = '0;
                  l_d.mask_inversion_lane = {2{bitv}};
                  l_d.dmi_oe_n = {2{~l_q.w.dbi}};
               end
               DRC_K_FRD: begin
                  // Reading leaves the entry untouched
                  {l_d.mask_inversion_lane, l_d.dq} = l_q.mem[l_q.w.idx][l_q.beat];
                  l_d.dq_oe_n = '0;
                  l_d.dmi_oe_n = '0;
               end
               default: begin
                  l_d.mem[l_q.w.idx][l_q.beat] =
                     {mask_inversion_lane_in, dq_in};
               end
            endcase
            l_d.beat = l_q.beat + 4'h1;
            if (l_q.beat == `DRC_BEAT_LAST) begin
               l_d.st = DRC_IDLE;
               l_d.ack = ~l_q.ack;
            end
         end
         default: l_d.st = DRC_IDLE;
      endcase
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         l_q <= '0;
         l_q.dq_oe_n <= '1;
         l_q.dmi_oe_n <= '1;
      end else begin
         l_q <= l_d;
      end
   end

   assign dq_out = l_q.dq;
   assign dq_oe_n = l_q.dq_oe_n;
   assign mask_inversion_lane_out = l_q.mask_inversion_lane;
   assign mask_inversion_lane_oe_n = l_q.dmi_oe_n;
   assign wr_ptr = s_q.wptr;
   assign rd_ptr = s_q.rptr;
   assign read_bus_inversion_enable = s_q.dbi;
   assign launch_overrun = s_q.overrun;

   // Command side checks
   chk_mpc_nop: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_MPC && !cmd_op[6] |=> !s_q.pend_v)
      else $error("MPC with op bit6 low not a NOP");

   chk_nop_ptrs: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_MPC && !cmd_op[6] |=> $stable(wr_ptr) && $stable(rd_ptr))
      else $error("MPC with op bit6 low moved a pointer");

   chk_wptr_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_FWR
      |=> s_q.wptr == drc_next($past(s_q.wptr)))
      else $error("FIFO write did not advance pointer");

   chk_frd_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_FRD
      |=> s_q.rptr == drc_next($past(s_q.rptr)) && $stable(s_q.wptr))
      else $error("FIFO read did not advance read pointer only");

   chk_rd_both: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_RD |=> s_q.wptr == drc_next($past(s_q.wptr))
      && s_q.rptr == drc_next($past(s_q.rptr)))
      else $error("Array read did not advance both pointers");

   chk_rda_both: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_RDA |=> s_q.wptr == drc_next($past(s_q.wptr))
      && s_q.rptr == drc_next($past(s_q.rptr)))
      else $error("Read with precharge did not advance both pointers");

   chk_rptr_wrap: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_FRD
      && s_q.rptr == 3'h4 |=> s_q.rptr == 3'h0)
      else $error("Read pointer did not wrap after last entry");

   chk_ptr_range: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_ptr <= `DRC_FIFO_LAST && rd_ptr <= `DRC_FIFO_LAST)
      else $error("FIFO pointer beyond last entry");

   chk_ptr_reset: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code inside {DRC_PDE, DRC_SRPDE} |=> wr_ptr == 3'h0
      && rd_ptr == 3'h0)
      else $error("Pointers not reset on power-down");

   chk_cal_latency: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_CAL
      |=> s_q.pipe[$past(read_latency)].v)
      else $error("Calibration not scheduled at read latency");

   chk_wr_latency: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_FWR
      |=> s_q.pipe[$past(write_latency)].v)
      else $error("FIFO write not scheduled at write latency");

   chk_rd_latency: assert property (
      @(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v && s_q.pend_k == DRC_K_FRD
      |=> s_q.pipe[$past(read_latency)].v)
      else $error("FIFO read not scheduled at read latency");

   // Strobe side checks
   chk_lsb_first: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.beat == 4'h0
      |=> dq_out[0] == (l_q.w.pat1[0] ^ l_q.w.mask[0]) && !dq_oe_n[0])
      else $error("First calibration beat wrong");

   chk_second_byte: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.beat == 4'h8
      |=> dq_out[0] == (l_q.w.pat2[0] ^ l_q.w.mask[0]))
      else $error("Second pattern byte not sent after the first");

   chk_upper_lane: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.beat == 4'h0
      |=> dq_out[8] == (l_q.w.pat1[0] ^ l_q.w.mask[8]))
      else $error("Upper lane not steered by upper mask bit");

   chk_dmi_plain: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL
      |=> mask_inversion_lane_out[1] == (dq_out[1] ^ l_q.w.mask[1]))
      else $error("Inversion lane pattern was inverted");

   chk_dmi_first: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.beat == 4'h0
      |=> mask_inversion_lane_out == {2{l_q.w.pat1[0]}})
      else $error("Inversion lane first beat wrong");

   chk_dmi_off: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && !l_q.w.dbi
      |=> mask_inversion_lane_oe_n == 2'b11)
      else $error("Inversion lane driven with bus inversion off");

   chk_dmi_on: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.w.dbi
      |=> mask_inversion_lane_oe_n == 2'b00)
      else $error("Inversion lane released with bus inversion on");

   chk_burst_len: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_IDLE && l_q.req_s2 != l_q.req_s3
      |-> ##16 l_q.st == DRC_BURST ##1 l_q.st == DRC_IDLE)
      else $error("Burst is not 16 beats");

   chk_idle_off: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_IDLE |=> dq_oe_n == 16'hffff)
      else $error("Data lanes driven outside a burst");

   chk_frd_drive: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_FRD |=> dq_oe_n == 16'h0000)
      else $error("FIFO read burst not driven");

   chk_fwr_store: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_FWR
      |=> l_q.mem[$past(l_q.w.idx)][$past(l_q.beat)][15:0] == $past(dq_in))
      else $error("FIFO write beat not stored");

   chk_fifo_keep: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_FRD
      |=> l_q.mem == $past(l_q.mem))
      else $error("FIFO read altered stored data");

   cov_cal: cover property (@(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_CAL && l_q.w.dbi);

   cov_fwr: cover property (@(posedge link_clk) disable iff (!reset_n)
      l_q.st == DRC_BURST && l_q.w.k == DRC_K_FWR && l_q.w.idx == 3'h4);

   cov_frd_wrap: cover property (@(posedge clk) disable iff (!reset_n)
      rd_ptr == 3'h4 ##[1:40] rd_ptr == 3'h0);

   cov_overrun: cover property (@(posedge clk) disable iff (!reset_n)
      launch_overrun);

   cov_rd_after_cal: cover property (@(posedge clk) disable iff (!reset_n)
      cmd_code == DRC_CAS2 && s_q.pend_v ##1 cmd_code == DRC_RD);
endmodule // drc_train

/* bench/drc_ctrl_model.sv */
`timescale 1ns/1ps
module drc_ctrl_model (
   // Frame control from the bench
   input wire logic run,
   input wire logic drv,
   input wire logic [17:0] wdat,
   // Strobe and data lanes
   output logic link_clk,
   output logic [15:0] dq_in,
   output logic [1:0] mask_inversion_lane_in
);
   // Strobe toggles only inside frames
   initial begin
      link_clk = 1'b0;
      #17;
      forever begin
         #62.5 link_clk = run ? ~link_clk : 1'b0;
      end
   end
   // Released lanes flip every beat
   initial {mask_inversion_lane_in, dq_in} = 18'h0;
   always @(negedge link_clk) begin
      {mask_inversion_lane_in, dq_in} <=
         drv ? wdat : ~{mask_inversion_lane_in, dq_in};
   end
endmodule // drc_ctrl_model

/* bench/dram_read_calib_and_training_fifo_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module dram_read_calib_and_training_fifo_test;
   import drc_pkg::*;
   logic clk, reset_n, run, drv, dbi, link_clk, ovr, rbi;
   drc_cmd_t cmd_code;
   logic [5:0] cmd_ma;
   logic [7:0] cmd_op, p1, p2;
   logic [4:0] rl, wl;
   logic [17:0] wdat;
   logic [17:0] wmem [5];
   logic [15:0] msk, dq_in, dq_out, dq_oe_n;
   logic [1:0] dmi_in, dmi_out, dmi_oe_n;
   logic [2:0] wr_ptr, rd_ptr;
   logic [31:0] seed = 32'd39;
   logic [39:0] expq [$];
   int n_errors = 0;
   int checks = 0;

   drc_train u_drc_train (.clk(clk), .reset_n(reset_n),
      .cmd_code(cmd_code), .cmd_ma(cmd_ma), .cmd_op(cmd_op),
      .read_latency(rl), .write_latency(wl), .link_clk(link_clk),
      .dq_in(dq_in), .mask_inversion_lane_in(dmi_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .mask_inversion_lane_out(dmi_out),
      .mask_inversion_lane_oe_n(dmi_oe_n), .wr_ptr(wr_ptr),
      .rd_ptr(rd_ptr), .read_bus_inversion_enable(rbi),
      .launch_overrun(ovr));
   drc_ctrl_model u_drc_ctrl_model (.run(run), .drv(drv), .wdat(wdat),
      .link_clk(link_clk), .dq_in(dq_in), .mask_inversion_lane_in(dmi_in));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic stop_test();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmd(input drc_cmd_t c, input logic [5:0] ma,
      input logic [7:0] op);
      @(posedge clk);
      cmd_code <= c;
      cmd_ma <= ma;
      cmd_op <= op;
   endtask

   // Command pair, optional follower, then one strobe frame
   task automatic pair(input logic [7:0] op, input drc_cmd_t after);
      cmd(DRC_MPC, 6'h0, op);
      run <= 1'b1;
      cmd(DRC_CAS2, 6'h0, 8'h0);
      cmd(after, 6'h0, 8'h0);
      cmd(DRC_NOP, 6'h0, 8'h0);
      repeat (90) @(posedge clk);
      run <= 1'b0;
      drv <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task automatic push_cal();
      logic bt;
      for (int b = 0; b < 16; b++) begin
         bt = b < 8 ? p1[b] : p2[b-8];
         expq.push_back({dbi ? 20'hfffff : 20'hcffff, dbi ? 2'b00 : 2'b11,
            dbi ? {bt, bt} : 2'b00, {16{bt}} ^ msk});
      end
   endtask

   // Burst beats checked against the oldest note
   always @(negedge link_clk) begin
      logic [39:0] e;
      if (reset_n && dq_oe_n === 16'h0) begin
         if (expq.size() == 0)
            `CHK(dq_oe_n, 16'hffff)
         else begin
            e = expq.pop_front();
            `CHK({dmi_oe_n, dmi_out, dq_out} & e[39:20], e[19:0])
         end
      end
   end

   // No burst may be dropped in these scenarios
   always @(negedge clk) begin
      if (reset_n && ovr !== 1'b0)
         `CHK(ovr, 1'b0)
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // About five and a half times the expected run
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end

   initial begin
      reset_n = 1'b0;
      run = 1'b1;
      drv = 1'b0;
      wdat = 18'h0;
      cmd_code = DRC_NOP;
      cmd_ma = 6'h0;
      cmd_op = 8'h0;
      rl = 5'd2 + 5'(rnd() % 6);
      wl = 5'd2 + 5'(rnd() % 6);
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      run <= 1'b0;
      // Default pattern, inversion lanes released
      p1 = 8'h5a;
      p2 = 8'h3c;
      msk = 16'h5555;
      dbi = 1'b0;
      push_cal();
      pair(8'h43, DRC_NOP);
      // Programmed pattern, inversion lanes on, array read behind
      p1 = 8'h1c;
      p2 = 8'h59;
      msk = 16'(rnd());
      dbi = 1'b1;
      cmd(DRC_MRW, 6'h20, p1);
      cmd(DRC_MRW, 6'h28, p2);
      cmd(DRC_MRW, 6'h0f, msk[7:0]);
      cmd(DRC_MRW, 6'h14, msk[15:8]);
      cmd(DRC_MRW, 6'h03, 8'h40);
      push_cal();
      pair(8'h43, DRC_RD);
      `CHK(rbi, 1'b1)
      `CHK({wr_ptr, rd_ptr}, 6'o11)
      pair(8'h07, DRC_NOP);
      `CHK({wr_ptr, rd_ptr}, 6'o11)
      cmd(DRC_PDE, 6'h0, 8'h0);
      cmd(DRC_NOP, 6'h0, 8'h0);
      #1;
      `CHK({wr_ptr, rd_ptr}, 6'o00)
      repeat (8) @(posedge clk);
      // Five writes, then ten reads so the pointers realign
      for (int i = 0; i < 5; i++) begin
         wmem[i] = 18'(rnd());
         wdat <= wmem[i];
         drv <= 1'b1;
         pair(8'h47, DRC_NOP);
         `CHK(wr_ptr, 3'((i + 1) % 5))
      end
      for (int i = 0; i < 10; i++) begin
         for (int b = 0; b < 16; b++)
            expq.push_back({20'hfffff, 2'b00, wmem[i % 5]});
         pair(8'h41, DRC_NOP);
         `CHK(rd_ptr, 3'((i + 1) % 5))
      end
      `CHK(expq.size(), 0)
      stop_test();
   end
endmodule // dram_read_calib_and_training_fifo_test
